/* design/solenoid_cfg_regs.sv */
// Purpose: Per-channel configuration, status reply and error readout.
// Assumes: Fault flags and reference detect come from analog, asynchronous.
// Notes:   Replies go out in the frame after the one that asked for them.
`default_nettype none
`include "sdrv_consts.svh"

// Behaviour
// - Dither frequency is 1.76 MHz over code times 336, code nonzero.
// - Dither code is seven bits; 7F gives the lowest, about 41.2 Hz.
// - Config frame: channel in bit 15, bits 14:13 are 10, echoed back.
// - Config write ignores incoming bits 12 down to 6.
// - Bit 5 enables the probe pull-up on the sense pin, reset 0.
// - Bits 4:3 select edge rate 12, 6, 3, 1.2 V/us; reset 3.
// - Bits 2:0 select hysteresis 40 to 110 mVpp; reset 0.
// - Reply bit 12 reports open load or short to ground.
// - Reply bit 11 reports load shorted to battery.
// - Reply bit 10 reports overtemperature.
// - Reply bits 9 to 7 are always zero.
// - Reply bit 6 is 0 for external reference, 1 for internal.
// - Reply bits 5:0 return the stored settings of that channel.
// - Error index picks the register sent in the next frame.
// - Error reply holds index in 10:8, value in 7:0, 12:11 zero.
// - Indices 0-4 error registers, 5 revision, 6 and 7 read 00.
module solenoid_cfg_regs import sdrv_pkg::*; #(
  parameter int          NUM_CH   = 2,
  // Revision value is arbitrary.
  parameter logic [7:0]  REV_CODE = 8'hA5
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 mosi,
  output var  logic                 miso,
  output var  logic                 miso_oe,
  input  wire logic [NUM_CH-1:0]    open_or_ground_fault,
  input  wire logic [NUM_CH-1:0]    battery_short_fault,
  input  wire logic [NUM_CH-1:0]    overheat_fault,
  input  wire logic                 ref_internal,
  input  wire logic [`ERR_BITS-1:0] err_corr,
  input  wire logic [7*NUM_CH-1:0]  dither_code,
  output logic      [NUM_CH-1:0]    fault_type_probe_en,
  output logic      [NUM_CH-1:0]    edge_rate_sel_hi,
  output logic      [NUM_CH-1:0]    edge_rate_sel_lo,
  output logic      [NUM_CH-1:0]    hysteresis_sel_2,
  output logic      [NUM_CH-1:0]    hysteresis_sel_1,
  output logic      [NUM_CH-1:0]    hysteresis_sel_0,
  output logic      [NUM_CH-1:0]    dither_wave
);

  // One channel bit in the frame addresses exactly two channels.
  if (NUM_CH != 2) begin : g_bad_ch
    $error("NUM_CH must be 2");
  end

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam logic [13:0] ACC_STEP = 14'(`DITHER_REF_KHZ);
  localparam logic [13:0] ACC_WRAP = 14'(`CLK_KHZ - `DITHER_REF_KHZ);
  localparam logic [7:0]  HALF_DIV = 8'(`DITHER_DIV / 2);

  spi_frame_if frm ();

  // Three flag groups per channel plus the shared reference detect.
  logic [3*NUM_CH:0] flt_m;
  logic [3*NUM_CH:0] flt_s;
  logic [NUM_CH-1:0] og_s;
  logic [NUM_CH-1:0] bs_s;
  logic [NUM_CH-1:0] ot_s;
  logic              ref_s;
  cfg_t              cfg [NUM_CH];
  word_t             reply;
  word_t             rx;
  logic              rx_ch;
  logic [2:0]        idx;
  logic              cfg_wr;
  logic              err_rd;
  logic [6:0]        err_base;
  logic [7:0]        err_value;
  logic [13:0]       acc;
  logic              base_tick;

  assign frm.ce      = ce;
  assign frm.tx_word = reply;
  assign rx          = frm.rx_word;
  assign rx_ch       = rx[`CH_BIT];
  assign idx         = rx[`IDX_HI:`IDX_LO];
  assign cfg_wr      = ce & frm.rx_valid & (rx[`CMD_HI:`CMD_LO] == `CMD_CFG);
  assign err_rd      = ce & frm.rx_valid & (rx[`CMD_HI:`CMD_LO] == `CMD_ERR)
                       & (rx[`EXT_HI:`EXT_LO] == 2'h0);

  spi_frame_shifter u_shifter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .frm     (frm.shifter)
  );

  // --------------------------------------------------------------------
  // Status synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flt_m <= '0;
      flt_s <= '0;
    end else if (ce) begin
      flt_m <= {ref_internal, overheat_fault, battery_short_fault,
                open_or_ground_fault};
      flt_s <= flt_m;
    end
  end

  assign og_s  = flt_s[NUM_CH-1:0];
  assign bs_s  = flt_s[2*NUM_CH-1:NUM_CH];
  assign ot_s  = flt_s[3*NUM_CH-1:2*NUM_CH];
  assign ref_s = flt_s[3*NUM_CH];

  // --------------------------------------------------------------------
  // Per-channel settings and dither
  // --------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [14:0] dcnt;
    logic [14:0] half;
    logic [6:0]  code;

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cfg[ch] <= `CFG_RESET;
      end else if (cfg_wr && rx_ch == 1'(ch)) begin
        cfg[ch] <= rx[`CFG_HI:0];
      end
    end

    assign fault_type_probe_en[ch] = cfg[ch][5];
    assign edge_rate_sel_hi[ch]    = cfg[ch][4];
    assign edge_rate_sel_lo[ch]    = cfg[ch][3];
    assign hysteresis_sel_2[ch]    = cfg[ch][2];
    assign hysteresis_sel_1[ch]    = cfg[ch][1];
    assign hysteresis_sel_0[ch]    = cfg[ch][0];

    assign code = dither_code[7*ch +: 7];
    assign half = 15'(code) * 15'(HALF_DIV);

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dcnt            <= 15'h0000;
        dither_wave[ch] <= 1'b0;
      end else if (ce) begin
        if (code == 7'h00) begin
          dcnt            <= 15'h0000;
          dither_wave[ch] <= 1'b0;
        end else if (base_tick) begin
          if (dcnt >= half - 15'h0001) begin
            dcnt            <= 15'h0000;
            dither_wave[ch] <= ~dither_wave[ch];
          end else begin
            dcnt <= dcnt + 15'h0001;
          end
        end
      end
    end

    AST_DITHER_OFF: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ce && code == 7'h00 |=> !dither_wave[ch] && dcnt == 15'h0000)
      else $error("dither runs with zero code");
  end

  // Fractional step gives the reference tick rate from clk_sys on average;
  // single ticks jitter by one clk_sys period.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc       <= 14'h0000;
      base_tick <= 1'b0;
    end else if (ce) begin
      if (acc >= ACC_WRAP) begin
        acc       <= acc - ACC_WRAP;
        base_tick <= 1'b1;
      end else begin
        acc       <= acc + ACC_STEP;
        base_tick <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Reply word
  // --------------------------------------------------------------------
  always_comb begin
    err_base = (rx_ch ? `ERR_CH_BASE : 7'h00) + {1'b0, idx, 3'h0};
    if (idx <= `ERR_LAST_IDX) begin
      err_value = err_corr[err_base +: 8];
    end else if (idx == `REV_IDX) begin
      err_value = REV_CODE;
    end else begin
      err_value = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reply <= `REPLY_RESET;
    end else if (cfg_wr) begin
      reply <= {rx_ch, `CMD_CFG, og_s[rx_ch], bs_s[rx_ch], ot_s[rx_ch],
                3'h0, ref_s, rx[`CFG_HI:0]};
    end else if (err_rd) begin
      reply <= {rx_ch, `CMD_ERR, 2'h0, idx, err_value};
    end else if (ce && frm.rx_valid) begin
      reply <= `REPLY_RESET;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_cfg0;
    cfg_wr && !rx_ch;
  endsequence

  AST_CFG_STORE: assert property (
    s_cfg0 |=> cfg[0] == $past(rx[5:0]) && $stable(cfg[1]))
    else $error("channel write wrong");

  AST_CFG_ECHO: assert property (
    cfg_wr |=> reply[15:13] == {$past(rx_ch), `CMD_CFG})
    else $error("config header not echoed");

  AST_CFG_BACK: assert property (
    cfg_wr |=> reply[9:7] == 3'h0 && reply[5:0] == $past(rx[5:0]))
    else $error("config readback wrong");

  AST_REF_BIT: assert property (
    cfg_wr |=> reply[6] == $past(ref_s))
    else $error("reference bit wrong");

  AST_FLAGS: assert property (
    s_cfg0 |=> reply[12:10] == {$past(og_s[0]), $past(bs_s[0]),
                                $past(ot_s[0])})
    else $error("fault flags wrong");

  AST_ERR_IDX: assert property (
    err_rd |=> reply[15:8] == {$past(rx_ch), `CMD_ERR, 2'h0, $past(idx)})
    else $error("error reply header wrong");

  AST_ERR_ZERO: assert property (
    err_rd && idx > `REV_IDX |=> reply[7:0] == 8'h00)
    else $error("unused index not zero");

  AST_ERR_REV: assert property (
    err_rd && idx == `REV_IDX |=> reply[7:0] == REV_CODE)
    else $error("revision code wrong");

  AST_REPLY_HOLD: assert property (
    !(ce && frm.rx_valid) |=> $stable(reply))
    else $error("reply changed without a frame");

endmodule : solenoid_cfg_regs

`default_nettype wire

/* design/sdrv_consts.svh */
// Purpose: Frame layout, reset values and timing counts of the driver.
// Assumes: Included by its bare name from the solenoid_cfg_regs and spi_frame_shifter design files.
// Notes:   Definitions only.
`ifndef SDRV_CONSTS_SVH
`define SDRV_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define FRAME_BITS      16
`define FRAME_CNT_FULL  5'h10
`define FRAME_CNT_SAT   5'h1F
`define CH_BIT          15
`define CMD_HI          14
`define CMD_LO          13
`define CMD_CFG         2'h2
`define CMD_ERR         2'h3
`define EXT_HI          12
`define EXT_LO          11
`define IDX_HI          10
`define IDX_LO          8
`define CFG_HI          5
`define ERR_LAST_IDX    3'h4
`define REV_IDX         3'h5
`define ERR_CH_BASE     7'h28
`define ERR_BITS        80

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CFG_RESET       6'h18
`define REPLY_RESET     16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define CLK_KHZ         (1000000 / `CLK_PERIOD_NS)
`define DITHER_REF_KHZ  1760
`define DITHER_DIV      336

`endif

/* design/sdrv_pkg.sv */
// Purpose: Shared types of the solenoid driver command logic.
// Assumes: Compiled before every other design file.
// Notes:   Constants live in sdrv_consts.svh.
`default_nettype none

package sdrv_pkg;
  typedef enum logic [1:0] {
    SH_IDLE  = 2'h1,
    SH_SHIFT = 2'h2
  } shift_state_e;
  typedef logic [15:0] word_t;
  typedef logic [5:0]  cfg_t;
endpackage : sdrv_pkg

`default_nettype wire

/* design/spi_frame_if.sv */
// Purpose: Word-level link between the frame shifter and the register core.
// Assumes: Both ends run on clk_sys.
// Notes:   rx_valid is a one-cycle pulse while ce is high.
`default_nettype none

interface spi_frame_if;
  import sdrv_pkg::*;
  logic  ce;
  word_t rx_word;
  logic  rx_valid;
  word_t tx_word;
  modport shifter (input ce, input tx_word, output rx_word, output rx_valid);
  modport core    (output ce, output tx_word, input rx_word, input rx_valid);
endinterface : spi_frame_if

`default_nettype wire

/* design/spi_frame_shifter.sv */
// Purpose: SPI slave shifter, 16-bit frames, MSB first, mode 0.
// Assumes: SPI pins are asynchronous and far slower than clk_sys.
// Notes:   Reply word is latched when chip select falls.
`default_nettype none
`include "sdrv_consts.svh"

module spi_frame_shifter import sdrv_pkg::*; (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   mosi,
  output var  logic   miso,
  output var  logic   miso_oe,
  spi_frame_if.shifter frm
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [2:0]   sync_m;
  logic [2:0]   sync_s;
  logic         sclk_d;
  logic         cs_d;
  shift_state_e state;
  logic [4:0]   cnt;
  word_t        rx_sr;
  word_t        tx_sr;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_m <= 3'h2;
      sync_s <= 3'h2;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else if (frm.ce) begin
      sync_m <= {sclk, cs_n, mosi};
      sync_s <= sync_m;
      sclk_d <= sync_s[2];
      cs_d   <= sync_s[1];
    end
  end

  wire sclk_rise = sync_s[2] & ~sclk_d;
  wire sclk_fall = ~sync_s[2] & sclk_d;
  wire cs_fall   = ~sync_s[1] & cs_d;
  wire cs_rise   = sync_s[1] & ~cs_d;

  // --------------------------------------------------------------------
  // Frame state machine
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= SH_IDLE;
      cnt          <= 5'h00;
      rx_sr        <= 16'h0000;
      tx_sr        <= 16'h0000;
      miso         <= 1'b0;
      frm.rx_valid <= 1'b0;
      frm.rx_word  <= 16'h0000;
    end else if (frm.ce) begin
      frm.rx_valid <= 1'b0;
      case (state)
        SH_IDLE: begin
          if (cs_fall) begin
            state <= SH_SHIFT;
            cnt   <= 5'h00;
            tx_sr <= frm.tx_word;
            miso  <= frm.tx_word[`FRAME_BITS-1];
          end
        end
        SH_SHIFT: begin
          if (cs_rise) begin
            state <= SH_IDLE;
            if (cnt == `FRAME_CNT_FULL) begin
              frm.rx_valid <= 1'b1;
              frm.rx_word  <= rx_sr;
            end
          end else begin
            if (sclk_rise) begin
              rx_sr <= {rx_sr[`FRAME_BITS-2:0], sync_s[0]};
              tx_sr <= {tx_sr[`FRAME_BITS-2:0], 1'b0};
              if (cnt != `FRAME_CNT_SAT) begin
                cnt <= cnt + 5'h01;
              end
            end
            if (sclk_fall) begin
              miso <= tx_sr[`FRAME_BITS-1];
            end
          end
        end
        default: begin
          state <= SH_IDLE;
        end
      endcase
    end
  end

  // Output driver follows the synchronised select, so it never drives early.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      miso_oe <= 1'b0;
    end else if (frm.ce) begin
      miso_oe <= ~sync_s[1];
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_frame_end;
    frm.ce && state == SH_SHIFT && cs_rise;
  endsequence

  AST_FRAME_OK: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_frame_end and (cnt == `FRAME_CNT_FULL) |=>
      frm.rx_valid && frm.rx_word == $past(rx_sr))
    else $error("full frame not delivered");

  AST_FRAME_BAD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_frame_end and (cnt != `FRAME_CNT_FULL) |=> !frm.rx_valid)
    else $error("partial frame delivered");

endmodule : spi_frame_shifter

`default_nettype wire

/* verification/spi_host_model.sv */
// Purpose: Host-side SPI master model, mode 0, 16-bit frames, MSB first.
// Assumes: xfer is called at a falling edge of clk_sys.
// Notes:   MISO is read late in the high phase, because the device's
//          input synchronisers use up most of the low phase.
`default_nettype none

module spi_host_model import sdrv_pkg::*; (
  output var  logic  sclk,
  output var  logic  cs_n,
  output var  logic  mosi,
  input  wire logic  miso,
  input  wire logic  miso_oe,
  output var  word_t rx_word,
  output var  logic  rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b1;
    mosi     = 1'b0;
    rx_word  = 16'h0000;
    rx_valid = 1'b0;
  end

  // ---------------------------------------------------------------------
  // One frame; a short count makes a frame the device must drop
  // ---------------------------------------------------------------------
  task automatic xfer(input word_t tx, input int nbits);
    int i;
    cs_n = 1'b0;
    mosi = tx[15];
    #800;
    for (i = 15; i > 15 - nbits; i--) begin
      sclk = 1'b1;
      #400;
      rx_word[i] = (miso_oe === 1'b1) ? miso : 1'bx;
      sclk = 1'b0;
      mosi = (i > 0) ? tx[i-1] : ~tx[0];
      #400;
    end
    rx_valid = (nbits == 16);
    #400;
    cs_n     = 1'b1;
    mosi     = ~mosi;
    rx_valid = 1'b0;
    #800;
  endtask : xfer
endmodule : spi_host_model

`default_nettype wire

/* verification/test_solenoid_cfg_regs.sv */
// Purpose: Self-checking bench of the per-channel config and error readout.
// Assumes: The SPI host model makes 800 ns link clock periods.
// Notes:   Replies are queued by the driver and checked by a monitor.
`default_nettype none
`include "sdrv_consts.svh"

module test_solenoid_cfg_regs import sdrv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // Revision value is arbitrary.
  localparam logic [7:0] REV = 8'h3C;

  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic        sclk, cs_n, mosi, miso, miso_oe, rx_valid;
  logic        ref_internal = 1'b0;
  logic [1:0]  open_or_ground_fault = 2'h0;
  logic [1:0]  battery_short_fault  = 2'h0;
  logic [1:0]  overheat_fault       = 2'h0;
  logic [79:0] err_corr    = '0;
  logic [13:0] dither_code = 14'h0000;
  logic [1:0]  fault_type_probe_en, edge_rate_sel_hi, edge_rate_sel_lo;
  logic [1:0]  hysteresis_sel_2, hysteresis_sel_1, hysteresis_sel_0;
  logic [1:0]  dither_wave;
  word_t       rx_word, pend;
  word_t       exp_q[$];
  cfg_t        cfg[2];
  logic        ignore_rx = 1'b0;
  int          bad_count, total_checks, cyc, i, n;
  word_t       bad_cmds[4] = '{16'h0123, 16'hA456, 16'h6800, 16'hF0FF};

  always #50 clk_sys = ~clk_sys;

  solenoid_cfg_regs #(.NUM_CH(2), .REV_CODE(REV)) i_solenoid_cfg_regs (
    .clk_sys, .rst_n, .ce, .sclk, .cs_n, .mosi, .miso, .miso_oe,
    .open_or_ground_fault, .battery_short_fault, .overheat_fault,
    .ref_internal, .err_corr, .dither_code, .fault_type_probe_en,
    .edge_rate_sel_hi, .edge_rate_sel_lo, .hysteresis_sel_2,
    .hysteresis_sel_1, .hysteresis_sel_0, .dither_wave
  );

  spi_host_model i_spi_host_model (
    .sclk, .cs_n, .mosi, .miso, .miso_oe, .rx_word, .rx_valid
  );

  // ---------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------
  task automatic cmp(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] %0t run took too long", $time);
      close_out();
    end
  end

  always @(posedge rx_valid) begin
    if (ignore_rx) begin
    end else if (exp_q.size() == 0) begin
      bad_count++;
      $display("[ERR] %0t reply with nothing expected", $time);
    end else begin
      cmp(rx_word, exp_q.pop_front()); // reply
    end
  end

  // ---------------------------------------------------------------------
  // Reference model of the reply to the next frame
  // ---------------------------------------------------------------------
  function automatic word_t model(input word_t tx);
    logic       chn;
    logic [2:0] idx;
    logic [7:0] val;
    chn = tx[15];
    idx = tx[10:8];
    if (tx[14:13] == 2'b10) begin
      cfg[chn] = tx[5:0];
      return {chn, 2'b10, open_or_ground_fault[chn],
              battery_short_fault[chn], overheat_fault[chn], 3'b000,
              ref_internal, cfg[chn]};
    end
    if (tx[14:13] == 2'b11 && tx[12:11] == 2'b00) begin
      val = (idx < 3'h5) ? err_corr[chn*40 + idx*8 +: 8] :
            (idx == 3'h5) ? REV : 8'h00;
      return {chn, 2'b11, 2'b00, idx, val};
    end
    return 16'h0000;
  endfunction : model

  task automatic check_pins;
    int c;
    for (c = 0; c < 2; c++) begin
      cmp({10'h000, fault_type_probe_en[c], edge_rate_sel_hi[c],
           edge_rate_sel_lo[c], hysteresis_sel_2[c], hysteresis_sel_1[c],
           hysteresis_sel_0[c]}, {10'h000, cfg[c]});
    end
  endtask : check_pins

  // Flags change only between frames, so the value sampled at acceptance
  // is the one the model sees.
  task automatic flags;
    open_or_ground_fault = 2'($urandom);
    battery_short_fault  = 2'($urandom);
    overheat_fault       = 2'($urandom);
    ref_internal         = 1'($urandom);
  endtask : flags

  task automatic frame(input word_t tx);
    exp_q.push_back(pend);
    i_spi_host_model.xfer(tx, 16);
    pend = model(tx);
    @(negedge clk_sys);
    check_pins(); // stored settings
    cmp({15'h0000, miso_oe}, 16'h0000); // output released
  endtask : frame

  task automatic wait_rise(input int chn, output int cnt);
    logic prev;
    cnt  = 0;
    prev = dither_wave[chn];
    forever begin
      @(negedge clk_sys);
      cnt++;
      if ((prev === 1'b0 && dither_wave[chn] === 1'b1) || cnt > 20000) break;
      prev = dither_wave[chn];
    end
  endtask : wait_rise

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(32'hd0d6));
    err_corr = 80'({$urandom, $urandom, $urandom});
    pend     = `REPLY_RESET;
    cfg[0]   = `CFG_RESET;
    cfg[1]   = `CFG_RESET;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_pins(); // reset values
    cmp({14'h0000, dither_wave}, 16'h0000); // idle with code zero
    for (i = 0; i < 8; i++) begin
      flags();
      frame({i[0], 2'b10, 7'($urandom), 1'($urandom), i[2:1],
             3'($urandom)}); // each rate per channel
    end
    for (i = 0; i < 16; i++) begin
      flags();
      frame({i[3], 2'b11, 2'b00, i[2:0], 8'($urandom)});
    end
    for (i = 0; i < 4; i++) begin
      frame(bad_cmds[i]); // other commands
    end
    // A short frame is dropped: no write, reply kept.
    i_spi_host_model.xfer(16'h401F, 8); // short frame
    check_pins(); // nothing written
    ignore_rx = 1'b1;
    ce        = 1'b0;
    i_spi_host_model.xfer(16'hC007, 16);
    ce        = 1'b1;
    ignore_rx = 1'b0;
    repeat (4) @(negedge clk_sys);
    check_pins(); // frozen frame ignored
    flags();
    frame(16'hC02A); // config write
    frame(16'h6500); // revision index
    frame(16'h0000); // flush last reply
    dither_code = {7'h03, 7'h01};
    for (i = 0; i < 2; i++) begin
      wait_rise(i, n); // align to a rise
      wait_rise(i, n); // one full period
      total_checks++;
      // Period is code times 336 ticks of 1.76 MHz, in 100 ns cycles.
      if (n < (2*i+1)*3360000/1760 - 2 || n > (2*i+1)*3360000/1760 + 2) begin
        bad_count++; // dither period
        $display("[ERR] %0t dither period %0d cycles", $time, n);
      end
    end
    if (exp_q.size() != 0) begin // every reply seen
      bad_count++;
      $display("[ERR] %0t replies missing", $time);
    end
    close_out();
  end
endmodule : test_solenoid_cfg_regs

`default_nettype wire
